// *** logic/pms_pkg.sv ***
// Package of constants and types for the pack monitor scheduler
// ============================================================
// How it works
// - Positive sense difference means charge, negative discharge
// - Integrate current into signed counter, quantum step
// - Refresh each cell voltage once per measurement cycle, corrected
// - Start calibration after five seconds of idle-low bus
// - Calibrate converter offset and coulomb counter offset
// - Temperature source chosen: internal or external inputs
// - Sample presence input every second, low means present
// - Enter bus-off after two seconds both lines low
// - Leave bus-off only on a rising bus line
// - Bus ready within one millisecond after bus-off
// - Normal mode runs one cycle per second
// - Sleep mode runs cycles at configurable interval
// - Wake from sleep on current or failure
// - Shutdown stops all activity except bus-off tracking and fuse sensing
// - Balancing pulls down sense pin of bypassed cell
// - Balance only while charging and above threshold
// - Drive fuse pin on serious fault, sense it too
// - Inhibit or suspend charge outside temperature range
// - Broadcast charge current and voltage for range
// - Keep lifetime extremes of temperature and voltage
// - Optional packet check byte, master mode supported
package pms_pkg;
  localparam int CLK_HZ = 20000000;
  localparam int TICK_CYCLES = CLK_HZ;
  localparam int CAL_IDLE_S = 5;
  localparam int OFF_IDLE_S = 2;
  localparam int READY_US = 1000;
  localparam int CLK_NS = 50;
  localparam int READY_CYCLES = (READY_US * 1000) / CLK_NS;
  localparam int CELLS = 4;
  localparam int VW = 16;
  localparam int QW = 32;
  localparam logic [1:0] TSRC_INT = 2'h0;
  localparam logic [1:0] TSRC_EXT_A = 2'h1;
  localparam logic [1:0] TSRC_EXT_AB = 2'h2;
  typedef enum logic [1:0] {PMS_NORMAL, PMS_SLEEP, PMS_SHUTDOWN} pms_mode_type;
  typedef struct packed {
    logic [VW-1:0] current;
    logic [VW-1:0] volt;
  } pms_charge_req_type;
  typedef struct packed {
    logic signed [VW-1:0] scale;
    logic signed [VW-1:0] offset;
    logic signed [VW-1:0] gain_cal;
  } pms_corr_type;
endpackage

// *** logic/pms_bus_watch.sv ***
// Bus line watcher on the link clock: idle-low timing and bus-off
`timescale 1ns/1ps
`default_nettype none
module pms_bus_watch #(
  parameter int CAL_S = pms_pkg::CAL_IDLE_S,
  parameter int OFF_S = pms_pkg::OFF_IDLE_S
) (
  input wire logic link_clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic tick_i,
  output logic cal_req_o,
  output logic bus_off_o,
  output logic rise_o
);
  logic [1:0] scl_s, sda_s;
  logic scl_q, sda_q;
  logic [3:0] idle_s;
  wire both_low = !scl_s[1] && !sda_s[1];
  wire rise = (scl_s[1] && !scl_q) || (sda_s[1] && !sda_q);
  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_s <= {scl_s[0], scl_i};
      sda_s <= {sda_s[0], sda_i};
      scl_q <= scl_s[1];
      sda_q <= sda_s[1];
    end
  end
  // Idle seconds counted in link domain, tick arrives already synchronised
  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      idle_s <= 4'h0;
      bus_off_o <= 1'b0;
      cal_req_o <= 1'b0;
    end else begin
      cal_req_o <= 1'b0;
      if (rise || !both_low) begin
        idle_s <= 4'h0;
      end else if (tick_i && idle_s != 4'hF) begin
        idle_s <= idle_s + 4'h1;
        // One extra tick: the first may come just after the lines drop
        if (idle_s + 4'h1 == 4'(CAL_S + 1)) cal_req_o <= 1'b1;
      end
      if (rise) bus_off_o <= 1'b0;
      else if (both_low && idle_s > 4'(OFF_S)) bus_off_o <= 1'b1;
    end
  end
  assign rise_o = rise;
  AST_OFF_EXIT: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
    bus_off_o && !rise |=> bus_off_o) else $error("bus-off left without rise");
  AST_RISE_CLR: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
    rise |=> idle_s == 4'h0) else $error("idle count not cleared");
endmodule
`default_nettype wire

// *** logic/pms_sync.sv ***
// Two-flop level synchroniser and toggle-event crossing
`timescale 1ns/1ps
`default_nettype none
module pms_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic d_i,
  output logic q_o,
  output logic edge_o
);
  logic s0, s1, s2;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s0 <= 1'b0;
      s1 <= 1'b0;
      s2 <= 1'b0;
    end else begin
      s0 <= d_i;
      s1 <= s0;
      s2 <= s1;
    end
  end
  assign q_o = s1;
  assign edge_o = s1 ^ s2;
endmodule
`default_nettype wire

// *** logic/pms_top.sv ***
// Supervisory scheduler of the pack monitor
`timescale 1ns/1ps
`default_nettype none
module pack_monitor_scheduler #(
  parameter int TICK = pms_pkg::TICK_CYCLES,
  parameter int READY = pms_pkg::READY_CYCLES,
  parameter int CELLS = pms_pkg::CELLS
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic link_clk_i,
  input wire logic serial_clock_line_i,
  input wire logic serial_data_line_i,
  input wire logic system_present_n_i,
  input wire logic signed [pms_pkg::VW-1:0] sense_diff_i,
  input wire logic [CELLS*pms_pkg::VW-1:0] cell_raw_i,
  input wire pms_pkg::pms_corr_type corr_i,
  input wire logic [pms_pkg::VW-1:0] temp_int_i,
  input wire logic [pms_pkg::VW-1:0] thermistor_in_a_i,
  input wire logic [pms_pkg::VW-1:0] thermistor_in_b_i,
  input wire logic [1:0] temp_src_i,
  input wire logic [7:0] sleep_interval_i,
  input wire logic sleep_req_i,
  input wire logic shutdown_req_i,
  input wire logic failure_i,
  input wire logic secondary_fault_i,
  input wire logic frontend_reg_integrity_fault_i,
  input wire logic frontend_comm_fault_i,
  input wire logic fuse_pin_i,
  input wire logic [pms_pkg::VW-1:0] bal_thresh_i,
  input wire logic [CELLS-1:0] bal_need_i,
  input wire logic [pms_pkg::VW-1:0] chg_temp_lo_i,
  input wire logic [pms_pkg::VW-1:0] chg_temp_hi_i,
  input wire pms_pkg::pms_charge_req_type chg_std_i,
  input wire pms_pkg::pms_charge_req_type chg_alt_i,
  input wire logic [pms_pkg::VW-1:0] alt_range_temp_i,
  input wire logic pec_en_i,
  input wire logic master_en_i,
  output logic charging_o,
  output logic discharging_o,
  output logic signed [pms_pkg::QW-1:0] charge_count_o,
  output logic [CELLS*pms_pkg::VW-1:0] cell_volt_o,
  output logic cal_adc_o,
  output logic cal_cc_o,
  output logic [pms_pkg::VW-1:0] temp_o,
  output logic system_present_o,
  output logic bus_off_o,
  output logic bus_ready_o,
  output logic cycle_o,
  output pms_pkg::pms_mode_type mode_o,
  output logic [CELLS-1:0] cell_pull_o,
  output logic fuse_out_o,
  output logic fuse_oe_n_o,
  output logic fuse_intact_o,
  output logic chg_allow_o,
  output logic bcast_o,
  output pms_pkg::pms_charge_req_type bcast_data_o,
  output logic pec_en_o,
  output logic master_en_o,
  output logic [pms_pkg::VW-1:0] temp_max_o,
  output logic [pms_pkg::VW-1:0] temp_min_o,
  output logic [pms_pkg::VW-1:0] cell_max_o,
  output logic [pms_pkg::VW-1:0] cell_min_o
);
  localparam int VW = pms_pkg::VW;
  localparam int QW = pms_pkg::QW;

  function automatic logic [VW-1:0] correct(input logic [VW-1:0] raw,
                                            input pms_pkg::pms_corr_type c);
    logic signed [2*VW+1:0] p;
    p = $signed({2'b00, raw}) * $signed(c.scale);
    correct = VW'((p >>> (VW - 1)) + c.offset + c.gain_cal);
  endfunction

  // ============================================================
  // One-second tick
  logic [31:0] tick_cnt;
  logic tick;
  wire tick_end = tick_cnt == 32'(TICK - 1);
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt <= 32'h0;
      tick <= 1'b0;
    end else begin
      tick_cnt <= tick_end ? 32'h0 : tick_cnt + 32'h1;
      tick <= tick_end;
    end
  end

  // ============================================================
  // Crossings: tick into link domain, bus events back
  logic tick_tgl;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) tick_tgl <= 1'b0;
    else if (tick) tick_tgl <= !tick_tgl;
  end
  logic link_tick;
  pms_sync u_tick_sync (
    .clk_i(link_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(tick_tgl),
    .q_o(),
    .edge_o(link_tick)
  );
  logic lk_cal, lk_off;
  pms_bus_watch u_watch (
    .link_clk_i(link_clk_i),
    .rst_n_i(rst_n_i),
    .scl_i(serial_clock_line_i),
    .sda_i(serial_data_line_i),
    .tick_i(link_tick),
    .cal_req_o(lk_cal),
    .bus_off_o(lk_off),
    .rise_o()
  );
  logic cal_tgl;
  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) cal_tgl <= 1'b0;
    else if (lk_cal) cal_tgl <= !cal_tgl;
  end
  logic cal_evt, off_sync;
  pms_sync u_cal_sync (
    .clk_i(clock_i),
    .rst_n_i(rst_n_i),
    .d_i(cal_tgl),
    .q_o(),
    .edge_o(cal_evt)
  );
  pms_sync u_off_sync (
    .clk_i(clock_i),
    .rst_n_i(rst_n_i),
    .d_i(lk_off),
    .q_o(off_sync),
    .edge_o()
  );
  logic system_present_n_sync, fuse_sync;
  pms_sync u_system_present_n_sync (
    .clk_i(clock_i),
    .rst_n_i(rst_n_i),
    .d_i(system_present_n_i),
    .q_o(system_present_n_sync),
    .edge_o()
  );
  pms_sync u_fuse_sync (
    .clk_i(clock_i),
    .rst_n_i(rst_n_i),
    .d_i(fuse_pin_i),
    .q_o(fuse_sync),
    .edge_o()
  );

  // ============================================================
  // Power mode
  pms_pkg::pms_mode_type mode, next_mode;
  wire active = mode != pms_pkg::PMS_SHUTDOWN;
  wire chg = active && sense_diff_i > 0;
  wire dsg = active && sense_diff_i < 0;
  always_comb begin
    next_mode = mode;
    unique case (mode)
      pms_pkg::PMS_NORMAL: begin
        if (shutdown_req_i) next_mode = pms_pkg::PMS_SHUTDOWN;
        else if (sleep_req_i) next_mode = pms_pkg::PMS_SLEEP;
      end
      pms_pkg::PMS_SLEEP: begin
        if (shutdown_req_i) next_mode = pms_pkg::PMS_SHUTDOWN;
        else if (sense_diff_i != 0 || failure_i) next_mode = pms_pkg::PMS_NORMAL;
      end
      pms_pkg::PMS_SHUTDOWN: next_mode = pms_pkg::PMS_SHUTDOWN;
      default: next_mode = pms_pkg::PMS_NORMAL;
    endcase
  end
  logic [7:0] sleep_cnt;
  wire sleep_due = sleep_cnt + 8'h1 >= sleep_interval_i;
  wire cycle = tick && (mode == pms_pkg::PMS_NORMAL ||
                        (mode == pms_pkg::PMS_SLEEP && sleep_due));
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode <= pms_pkg::PMS_NORMAL;
      sleep_cnt <= 8'h0;
      cycle_o <= 1'b0;
    end else begin
      mode <= next_mode;
      cycle_o <= cycle;
      if (mode != pms_pkg::PMS_SLEEP || cycle) sleep_cnt <= 8'h0;
      else if (tick) sleep_cnt <= sleep_cnt + 8'h1;
    end
  end
  assign mode_o = mode;

  // ============================================================
  // Measurement
  logic [VW-1:0] tsel;
  always_comb begin
    unique case (temp_src_i)
      pms_pkg::TSRC_EXT_A: tsel = thermistor_in_a_i;
      pms_pkg::TSRC_EXT_AB: tsel = VW'(({1'b0, thermistor_in_a_i} +
                                       {1'b0, thermistor_in_b_i}) >> 1);
      default: tsel = temp_int_i;
    endcase
  end
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      charge_count_o <= '0;
      charging_o <= 1'b0;
      discharging_o <= 1'b0;
      cell_volt_o <= '0;
      temp_o <= '0;
      system_present_o <= 1'b0;
    end else begin
      charging_o <= chg;
      discharging_o <= dsg;
      if (active) charge_count_o <= charge_count_o + QW'(sense_diff_i);
      if (cycle) begin
        for (int i = 0; i < CELLS; i++) begin
          cell_volt_o[i*VW +: VW] <= correct(cell_raw_i[i*VW +: VW], corr_i);
        end
        temp_o <= tsel;
      end
      if (tick && active) system_present_o <= !system_present_n_sync;
    end
  end

  // ============================================================
  // Calibration, bus state
  logic [31:0] ready_cnt;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cal_adc_o <= 1'b0;
      cal_cc_o <= 1'b0;
      ready_cnt <= 32'h0;
      bus_off_o <= 1'b0;
      bus_ready_o <= 1'b1;
    end else begin
      cal_adc_o <= cal_evt && active;
      cal_cc_o <= cal_evt && active;
      bus_off_o <= off_sync;
      if (off_sync) begin
        bus_ready_o <= 1'b0;
        ready_cnt <= 32'h0;
      end else if (!bus_ready_o) begin
        ready_cnt <= ready_cnt + 32'h1;
        if (ready_cnt >= 32'(READY - 1)) bus_ready_o <= 1'b1;
      end
    end
  end
  assign pec_en_o = pec_en_i;
  assign master_en_o = master_en_i && bus_ready_o;

  // ============================================================
  // Balancing, fuse, charge control, logging
  logic [VW-1:0] vmax, vmin;
  always_comb begin
    vmax = cell_volt_o[VW-1:0];
    vmin = cell_volt_o[VW-1:0];
    for (int i = 1; i < CELLS; i++) begin
      if (cell_volt_o[i*VW +: VW] > vmax) vmax = cell_volt_o[i*VW +: VW];
      if (cell_volt_o[i*VW +: VW] < vmin) vmin = cell_volt_o[i*VW +: VW];
    end
  end
  wire temp_ok = temp_o >= chg_temp_lo_i && temp_o <= chg_temp_hi_i;
  wire blow = secondary_fault_i || frontend_reg_integrity_fault_i || frontend_comm_fault_i;
  logic logged;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cell_pull_o <= '0;
      fuse_out_o <= 1'b0;
      fuse_oe_n_o <= 1'b1;
      fuse_intact_o <= 1'b0;
      chg_allow_o <= 1'b0;
      bcast_o <= 1'b0;
      bcast_data_o <= '0;
      temp_max_o <= '0;
      temp_min_o <= '1;
      cell_max_o <= '0;
      cell_min_o <= '1;
      logged <= 1'b0;
    end else begin
      for (int i = 0; i < CELLS; i++) begin
        cell_pull_o[i] <= bal_need_i[i] && chg &&
                          cell_volt_o[i*VW +: VW] > bal_thresh_i;
      end
      if (active && blow) begin
        fuse_out_o <= 1'b1;
        fuse_oe_n_o <= 1'b0;
      end
      fuse_intact_o <= fuse_oe_n_o && !fuse_sync;
      chg_allow_o <= active && temp_ok;
      bcast_o <= cycle && master_en_i && bus_ready_o && temp_ok;
      if (cycle) begin
        bcast_data_o <= (temp_o >= alt_range_temp_i) ? chg_alt_i : chg_std_i;
        logged <= 1'b1;
      end
      if (logged && cycle_o) begin
        if (temp_o > temp_max_o) temp_max_o <= temp_o;
        if (temp_o < temp_min_o) temp_min_o <= temp_o;
        if (vmax > cell_max_o) cell_max_o <= vmax;
        if (vmin < cell_min_o) cell_min_o <= vmin;
      end
    end
  end

  // ============================================================
  // Checks
  // Cycles spent waiting for the bus after bus-off has cleared
  logic [31:0] wait_run;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) wait_run <= 32'h0;
    else if (!off_sync && !bus_ready_o) wait_run <= wait_run + 32'h1;
    else wait_run <= 32'h0;
  end
  sequence s_bus_back;
    !off_sync ##1 !bus_ready_o;
  endsequence
  AST_CHG_SIGN: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    active && sense_diff_i > 0 |=> charging_o && !discharging_o) else $error("sign");
  AST_COUNT: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    active |=> charge_count_o == $past(charge_count_o) + QW'($past(sense_diff_i)))
    else $error("count step");
  AST_SHUT: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    mode == pms_pkg::PMS_SHUTDOWN |=> $stable(charge_count_o) && !cycle_o)
    else $error("activity in shutdown");
  AST_NORM_CYC: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    cycle_o |-> $past(tick)) else $error("cycle off tick");
  AST_BAL: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    |cell_pull_o |-> $past(chg)) else $error("balance without charge");
  AST_FUSE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    active && blow |=> fuse_out_o && !fuse_oe_n_o) else $error("fuse not driven");
  AST_TEMP: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !temp_ok |=> !chg_allow_o) else $error("charge outside range");
  AST_READY: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_bus_back |-> wait_run <= 32'(READY)) else $error("bus not ready in time");
  AST_WAKE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    mode == pms_pkg::PMS_SLEEP && !shutdown_req_i && failure_i |=>
    mode == pms_pkg::PMS_NORMAL) else $error("no wake");
endmodule
`default_nettype wire

// *** verification/pms_host_model.sv ***
// Host and charger side of the serial link, reduced to the two line levels
`timescale 1ns/1ps
`default_nettype none
module pms_host_model #(
  parameter int LAG = 1
) (
  input wire logic link_clk_i,
  input wire logic hold_low_i,
  output logic scl_o,
  output logic sda_o
);
  // ============================================================
  // Line drive
  // Released lines float high through their pull-ups
  logic [7:0] hist = 8'hFF;
  always @(posedge link_clk_i) begin
    hist <= {hist[6:0], !hold_low_i};
  end
  assign scl_o = hist[LAG-1];
  assign sda_o = hist[LAG-1];
endmodule
`default_nettype wire

// *** verification/pack_monitor_scheduler_bench.sv ***
// Self-checking bench of the pack monitor scheduler
`timescale 1ns/1ps
`default_nettype none
module pack_monitor_scheduler_bench;
  localparam int TICK = 20;
  localparam int READY = 10;
  localparam int VW = pms_pkg::VW;
  localparam int C = pms_pkg::CELLS;
  logic clock_i = 1'b0;
  logic link_clk_i = 1'b0;
  logic rst_n_i, serial_clock_line_i, serial_data_line_i, hold_low, fuse_ext;
  logic system_present_n_i, sleep_req_i, shutdown_req_i, failure_i, secondary_fault_i;
  logic frontend_reg_integrity_fault_i, frontend_comm_fault_i, fuse_pin_i;
  logic pec_en_i, master_en_i, cal_a, cal_c, x;
  logic signed [VW-1:0] sense_diff_i;
  logic [C*VW-1:0] cell_raw_i, cell_volt_o;
  pms_pkg::pms_corr_type corr_i;
  logic [VW-1:0] temp_int_i, thermistor_in_a_i, thermistor_in_b_i, bal_thresh_i;
  logic [VW-1:0] chg_temp_lo_i, chg_temp_hi_i, alt_range_temp_i, t, a, b, tmax, tmin;
  logic [VW-1:0] temp_o, temp_max_o, temp_min_o, cell_max_o, cell_min_o;
  logic [1:0] temp_src_i;
  logic [7:0] sleep_interval_i;
  logic [C-1:0] bal_need_i, cell_pull_o, e4;
  pms_pkg::pms_charge_req_type chg_std_i, chg_alt_i, bcast_data_o;
  logic charging_o, discharging_o, cal_adc_o, cal_cc_o, system_present_o, bus_off_o;
  logic bus_ready_o, cycle_o, fuse_out_o, fuse_oe_n_o, fuse_intact_o, chg_allow_o;
  logic bcast_o, pec_en_o, master_en_o;
  logic signed [pms_pkg::QW-1:0] charge_count_o, c0;
  pms_pkg::pms_mode_type mode_o;
  int fails = 0;
  int checks_done = 0;
  int k, g, k1;

  // ============================================================
  // Design, partner and clocks
  pack_monitor_scheduler #(.TICK(TICK), .READY(READY)) pack_monitor_scheduler_i (
    .clock_i, .rst_n_i, .link_clk_i, .serial_clock_line_i, .serial_data_line_i,
    .system_present_n_i, .sense_diff_i, .cell_raw_i, .corr_i, .temp_int_i,
    .thermistor_in_a_i, .thermistor_in_b_i, .temp_src_i, .sleep_interval_i,
    .sleep_req_i, .shutdown_req_i, .failure_i, .secondary_fault_i,
    .frontend_reg_integrity_fault_i, .frontend_comm_fault_i, .fuse_pin_i,
    .bal_thresh_i, .bal_need_i, .chg_temp_lo_i, .chg_temp_hi_i, .chg_std_i,
    .chg_alt_i, .alt_range_temp_i, .pec_en_i, .master_en_i, .charging_o,
    .discharging_o, .charge_count_o, .cell_volt_o, .cal_adc_o, .cal_cc_o, .temp_o,
    .system_present_o, .bus_off_o, .bus_ready_o, .cycle_o, .mode_o, .cell_pull_o,
    .fuse_out_o, .fuse_oe_n_o, .fuse_intact_o, .chg_allow_o, .bcast_o, .bcast_data_o,
    .pec_en_o, .master_en_o, .temp_max_o, .temp_min_o, .cell_max_o, .cell_min_o
  );
  pms_host_model pms_host_model_i (
    .link_clk_i, .hold_low_i(hold_low), .scl_o(serial_clock_line_i),
    .sda_o(serial_data_line_i)
  );
  always #25 clock_i = ~clock_i;
  initial begin
    #2.7;
    forever #6 link_clk_i = ~link_clk_i;
  end
  // Fuse pin level seen by both parties
  assign fuse_pin_i = (fuse_oe_n_o === 1'b0) ? fuse_out_o : fuse_ext;
  always @(posedge clock_i) begin
    if (cal_adc_o === 1'b1) cal_a <= 1'b1;
    if (cal_cc_o === 1'b1) cal_c <= 1'b1;
  end

  // ============================================================
  // Helpers
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic wait_lv(ref logic s, input logic v, input int lim);
    k = 0;
    while (s !== v && k < lim) begin
      @(negedge clock_i);
      k++;
    end
  endtask
  task automatic gap(input int lim);
    @(negedge clock_i);
    wait_lv(cycle_o, 1'b1, lim);
    @(negedge clock_i);
    wait_lv(cycle_o, 1'b1, lim);
    g = k + 1;
  endtask
  task automatic upd(input logic [VW-1:0] v);
    if (v > tmax) tmax = v;
    if (v < tmin) tmin = v;
  endtask
  function automatic logic [VW-1:0] exp_temp(logic [1:0] s, logic [VW-1:0] i, p, q);
    logic [VW:0] sum;
    sum = p + q;
    if (s == pms_pkg::TSRC_EXT_A) return p;
    if (s == pms_pkg::TSRC_EXT_AB) return sum[VW:1];
    return i;
  endfunction
  function automatic logic [VW-1:0] exp_cell(logic [VW-1:0] r);
    logic signed [2*VW+1:0] p;
    p = $signed({2'b00, r}) * corr_i.scale;
    return VW'((p >>> (VW - 1)) + corr_i.offset + corr_i.gain_cal);
  endfunction
  task automatic give_verdict();
    if (fails == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    cyc(8000);
    fails++;
    give_verdict();
  end

  // ============================================================
  // Tests
  initial begin
    k = $urandom(79114);
    {rst_n_i, hold_low, fuse_ext, sleep_req_i, shutdown_req_i, failure_i} = '0;
    {secondary_fault_i, frontend_reg_integrity_fault_i, frontend_comm_fault_i} = '0;
    {pec_en_i, master_en_i, sense_diff_i, temp_src_i, cal_a, cal_c} = '0;
    system_present_n_i = 1'b1;
    cell_raw_i = {$urandom, $urandom};
    corr_i = 48'({$urandom, $urandom});
    {chg_std_i, chg_alt_i} = {$urandom, $urandom};
    alt_range_temp_i = VW'($urandom);
    {thermistor_in_a_i, thermistor_in_b_i, bal_thresh_i} = '0;
    temp_int_i = 16'h0040;
    tmax = 16'h0040;
    tmin = 16'h0040;
    chg_temp_lo_i = 16'h0010;
    chg_temp_hi_i = 16'h0080;
    sleep_interval_i = 8'h03;
    bal_need_i = '1;
    cyc(6);
    @(negedge clock_i);
    chk("rst_ready", 1, bus_ready_o);
    chk("rst_fuse_oe_n", 1, fuse_oe_n_o);
    chk("rst_temp_min", 16'hFFFF, temp_min_o);
    chk("rst_mode", pms_pkg::PMS_NORMAL, mode_o);
    cyc(1);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      cyc(1);
      {master_en_i, pec_en_i} <= 2'(i);
      @(negedge clock_i);
      chk("pec_en", i % 2, pec_en_o);
      chk("master_en", i / 2, master_en_o);
    end
    wait_lv(bcast_o, 1'b1, 2 * TICK + 4);
    chk("bcast", 1, bcast_o);
    chk("bcast_data", (temp_int_i >= alt_range_temp_i) ? chg_alt_i : chg_std_i, bcast_data_o);
    for (int i = 0; i < 10; i++) begin
      cyc(1);
      sense_diff_i <= (i < 3) ? VW'(i - 1) : (i == 3) ? 16'sh8000 : VW'($urandom);
      cyc(3);
      @(negedge clock_i);
      c0 = charge_count_o;
      cyc(4);
      @(negedge clock_i);
      chk("charging", sense_diff_i > 0, charging_o);
      chk("discharging", sense_diff_i < 0, discharging_o);
      chk("charge_count", 32'(4 * sense_diff_i), 32'(charge_count_o - c0));
    end
    gap(2 * TICK);
    chk("cycle_gap", TICK, g);
    for (int i = 0; i < 7; i++) begin
      t = (i == 0) ? 16'h0050 : (i == 1) ? 16'h0090 : 16'h0008;
      a = VW'($urandom & 32'h3FFF);
      b = VW'($urandom & 32'h3FFF);
      cyc(1);
      temp_src_i <= (i < 3) ? 2'h0 : 2'(i - 3);
      temp_int_i <= t;
      {thermistor_in_a_i, thermistor_in_b_i} <= {a, b};
      cyc(2 * TICK + 4);
      @(negedge clock_i);
      t = exp_temp(temp_src_i, t, a, b);
      upd(t);
      chk("temp", t, temp_o);
      if (i < 3) chk("chg_allow", i == 0, chg_allow_o);
    end
    cyc(3);
    @(negedge clock_i);
    chk("temp_max", tmax, temp_max_o);
    chk("temp_min", tmin, temp_min_o);
    a = 16'h0000;
    b = 16'hFFFF;
    for (int j = 0; j < C; j++) begin
      t = exp_cell(cell_raw_i[j*VW +: VW]);
      chk("cell_volt", t, cell_volt_o[j*VW +: VW]);
      if (t > a) a = t;
      if (t < b) b = t;
    end
    chk("cell_max", a, cell_max_o);
    chk("cell_min", b, cell_min_o);
    cyc(1);
    system_present_n_i <= 1'b0;
    wait_lv(system_present_o, 1'b1, 2 * TICK + 5);
    chk("present", 1, system_present_o);
    cyc(1);
    system_present_n_i <= 1'b1;
    wait_lv(system_present_o, 1'b0, 2 * TICK + 5);
    chk("absent", 0, system_present_o);
    for (int i = 0; i < 3; i++) begin
      cyc(1);
      sense_diff_i <= i ? 16'sd5 : -16'sd5;
      bal_thresh_i <= (i == 1) ? 16'hFFFF : 16'h0000;
      bal_need_i <= (i == 2) ? C'($urandom) : '1;
      cyc(2 * TICK + 4);
      @(negedge clock_i);
      for (int j = 0; j < C; j++) begin
        e4[j] = i == 2 && bal_need_i[j] && cell_volt_o[j*VW +: VW] > bal_thresh_i;
      end
      chk("cell_pull", 32'(e4), 32'(cell_pull_o));
    end
    cyc(1);
    sense_diff_i <= '0;
    hold_low <= 1'b1;
    wait_lv(bus_off_o, 1'b1, 3 * TICK + 20);
    k1 = k;
    chk("bus_off", 1, bus_off_o);
    chk("bus_off_late", 1, k1 >= 2 * TICK);
    wait_lv(cal_a, 1'b1, 4 * TICK + 20);
    chk("cal_adc", 1, cal_a);
    chk("cal_cc", 1, cal_c);
    chk("cal_late", 1, k + k1 >= 5 * TICK);
    cyc(1);
    hold_low <= 1'b0;
    wait_lv(bus_off_o, 1'b0, 20);
    chk("bus_off_clear", 0, bus_off_o);
    wait_lv(bus_ready_o, 1'b1, READY + 20);
    chk("bus_ready", 1, bus_ready_o);
    cyc(1);
    hold_low <= 1'b1;
    cyc(TICK + TICK / 2);
    hold_low <= 1'b0;
    cyc(2);
    hold_low <= 1'b1;
    wait_lv(bus_off_o, 1'b1, 3 * TICK + 20);
    chk("idle_restart", 1, k >= 2 * TICK && bus_off_o === 1'b1);
    cyc(1);
    hold_low <= 1'b0;
    sleep_req_i <= 1'b1;
    cyc(5);
    @(negedge clock_i);
    chk("mode_sleep", pms_pkg::PMS_SLEEP, mode_o);
    gap(4 * TICK);
    gap(4 * TICK);
    chk("sleep_gap", 3 * TICK, g);
    for (int i = 0; i < 2; i++) begin
      cyc(1);
      if (i == 0) sense_diff_i <= 16'sd7;
      else failure_i <= 1'b1;
      sleep_req_i <= 1'b0;
      cyc(4);
      @(negedge clock_i);
      chk("wake", pms_pkg::PMS_NORMAL, mode_o);
      cyc(1);
      {sense_diff_i, failure_i} <= '0;
      sleep_req_i <= 1'b1;
      cyc(5);
    end
    cyc(1);
    sleep_req_i <= 1'b0;
    fuse_ext <= 1'b0;
    cyc(4);
    @(negedge clock_i);
    x = fuse_intact_o;
    cyc(1);
    fuse_ext <= 1'b1;
    cyc(4);
    @(negedge clock_i);
    chk("fuse_sense", 1, x !== fuse_intact_o);
    cyc(1);
    secondary_fault_i <= 1'b1;
    cyc(4);
    @(negedge clock_i);
    chk("fuse_oe_n", 0, fuse_oe_n_o);
    chk("fuse_out", 1, fuse_out_o);
    cyc(1);
    shutdown_req_i <= 1'b1;
    sense_diff_i <= 16'sd100;
    cyc(4);
    @(negedge clock_i);
    chk("mode_off", pms_pkg::PMS_SHUTDOWN, mode_o);
    c0 = charge_count_o;
    g = 0;
    repeat (3 * TICK) begin
      @(negedge clock_i);
      if (cycle_o !== 1'b0) g++;
    end
    chk("off_cycles", 0, g);
    chk("off_count", c0, charge_count_o);
    rst_n_i <= 1'b0;
    cyc(3);
    @(negedge clock_i);
    chk("rst_again_mode", pms_pkg::PMS_NORMAL, mode_o);
    chk("rst_again_fuse", 1, fuse_oe_n_o);
    give_verdict();
  end
endmodule
`default_nettype wire
